// *** rtl/arr_avalon_slave.sv ***
// Avalon-MM slave with waitrequest: decode, handshake and registered read data
`timescale 1ns/10ps
module arr_avalon_slave (
  // Clock and reset
  input  logic                   ref_clk,
  input  logic                   rst_b,
  // Avalon-MM
  input  logic [13:0]            avsAddress,
  input  logic                   avsRead,
  input  logic                   avsWrite,
  output logic [31:0]            avsReaddata,
  output logic                   avsWaitrequest,
  // Core side
  arr_core_if.slave              core
);
  arr_pkg::arr_bus_state_type    state_q;
  arr_pkg::arr_bus_state_type    state_d;
  logic                          wait_q;
  logic                          wait_d;
  logic [31:0]                   rdata_q;
  logic [31:0]                   rdata_d;
  logic                          request;

  assign request          = avsRead | avsWrite;
  // One strobe per transfer: only in the idle cycle that sees the request
  assign core.readStrobe  = avsRead & (state_q == arr_pkg::ST_IDLE);
  assign core.writeStrobe = avsWrite & (state_q == arr_pkg::ST_IDLE);
  assign core.selUpper    = arr_pkg::arr_hit(avsAddress, arr_pkg::UPPER_IDX);
  assign core.selLower    = arr_pkg::arr_hit(avsAddress, arr_pkg::LOWER_IDX);

  always_comb begin
    state_d = state_q;
    rdata_d = rdata_q;
    case (state_q)
      arr_pkg::ST_IDLE: begin
        if (request) begin
          state_d = arr_pkg::ST_ANSWER;
        end
        if (core.readStrobe) begin
          rdata_d = {arr_pkg::RDATA_PAD, core.readByte};
        end
      end
      arr_pkg::ST_ANSWER: begin
        state_d = arr_pkg::ST_IDLE;
      end
      default: begin
        state_d = arr_pkg::ST_IDLE;
      end
    endcase
    wait_d = (state_d == arr_pkg::ST_IDLE);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_q <= arr_pkg::ST_IDLE;
      wait_q  <= 1'b1;
      rdata_q <= arr_pkg::RDATA_RST;
    end else begin
      state_q <= state_d;
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  assign avsReaddata    = rdata_q;
  assign avsWaitrequest = wait_q;
endmodule

// *** rtl/arr_result_capture.sv ***
// Holds the most recent conversion result and its validity
`timescale 1ns/10ps
module arr_result_capture (
  // Clock and reset
  input  logic                   ref_clk,
  input  logic                   rst_b,
  // Converter side
  input  logic                   convDone,
  input  logic [12:0]            convResult,
  input  logic                   convOverflow,
  input  logic                   singleShotActive,
  // Status
  output logic                   resultValid,
  // Core side
  arr_core_if.capture            core
);
  logic [12:0]                   result_q;
  logic [12:0]                   result_d;
  logic                          overflow_q;
  logic                          overflow_d;
  logic                          valid_q;
  logic                          valid_d;

  always_comb begin
    result_d   = result_q;
    overflow_d = overflow_q;
    valid_d    = valid_q;
    if (convDone) begin
      result_d   = convResult;
      overflow_d = convOverflow;
      valid_d    = 1'b1;
    end else if (singleShotActive) begin
      // Value is meaningless while a single conversion runs
      valid_d    = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      // Zero is a convenience only; software gets no promise before a conversion
      result_q   <= arr_pkg::RESULT_RST;
      overflow_q <= 1'b0;
      valid_q    <= 1'b0;
    end else begin
      result_q   <= result_d;
      overflow_q <= overflow_d;
      valid_q    <= valid_d;
    end
  end

  assign core.liveResult   = result_q;
  assign core.liveOverflow = overflow_q;
  assign resultValid       = valid_q;
endmodule

// *** rtl/arr_result_registers.sv ***
// Converter result registers: upper byte, latched lower byte with overflow, Avalon-MM access
`timescale 1ns/10ps
module arr_result_registers (
  // Clock and reset
  input  logic                   ref_clk,
  input  logic                   rst_b,
  // Avalon-MM slave
  input  logic [13:0]            avsAddress,
  input  logic                   avsRead,
  input  logic                   avsWrite,
  input  logic [31:0]            avsWritedata,
  input  logic [3:0]             avsByteenable,
  output logic [31:0]            avsReaddata,
  output logic                   avsWaitrequest,
  // Converter result input
  input  logic                   convDone,
  input  logic [12:0]            convResult,
  input  logic                   convOverflow,
  input  logic                   singleShotActive,
  // Status
  output logic                   resultValid
);
  arr_core_if                    core ();

  logic [7:0]                    lowerLatch_q;
  logic [7:0]                    lowerLatch_d;
  logic [7:0]                    readByte;
  logic [7:0]                    liveLower;
  logic                          upperRead;
  logic                          lowerRead;

  // Write data and byte enables are accepted and dropped: nothing here is writable
  logic                          unusedWrite;
  assign unusedWrite = ^{avsWritedata, avsByteenable};

  arr_result_capture u_capture (
    .ref_clk          (ref_clk),
    .rst_b            (rst_b),
    .convDone         (convDone),
    .convResult       (convResult),
    .convOverflow     (convOverflow),
    .singleShotActive (singleShotActive),
    .resultValid      (resultValid),
    .core             (core.capture)
  );

  arr_avalon_slave u_slave (
    .ref_clk        (ref_clk),
    .rst_b          (rst_b),
    .avsAddress     (avsAddress),
    .avsRead        (avsRead),
    .avsWrite       (avsWrite),
    .avsReaddata    (avsReaddata),
    .avsWaitrequest (avsWaitrequest),
    .core           (core.slave)
  );

  assign upperRead = core.readStrobe & core.selUpper;
  assign lowerRead = core.readStrobe & core.selLower;

  // Lower byte as it would be built from the live result right now
  assign liveLower = {core.liveResult[arr_pkg::LOW_MSB:0], arr_pkg::RSVD_VALUE, core.liveOverflow};

  // Snapshot logic
  always_comb begin
    lowerLatch_d = lowerLatch_q;
    // Snapshot is taken in the same cycle the upper byte is sampled, so both halves match
    if (upperRead) begin
      lowerLatch_d = liveLower;
    end
    // No other path loads the snapshot, so later conversions cannot tear the pair
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      lowerLatch_q <= arr_pkg::BYTE_RST;
    end else begin
      lowerLatch_q <= lowerLatch_d;
    end
  end

  // Read data mux; unmapped addresses read zero
  always_comb begin
    readByte = arr_pkg::BYTE_RST;
    if (core.selUpper) begin
      readByte = core.liveResult[arr_pkg::UPPER_MSB:arr_pkg::UPPER_LSB];
    end else if (core.selLower) begin
      // A lower read without a prior upper read returns the last snapshot, not the live value
      readByte = lowerLatch_q;
    end
  end

  assign core.readByte = readByte;
  // Writes decode but reach no storage

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  a_upper_full_word: assert property (
    upperRead |=> ({avsReaddata[7:0], lowerLatch_q[7:3]} == $past(core.liveResult))
  ) else $error("upper byte and snapshot do not form the sampled result");

  a_upper_read_data: assert property (
    upperRead |=> (avsReaddata == {24'h00_0000, $past(core.liveResult[12:5])}) && !avsWaitrequest
  ) else $error("upper read data wrong");

  a_lower_bits_pos: assert property (
    upperRead ##1 (avsRead && !avsWaitrequest) ##2 lowerRead |=>
      (avsReaddata[7:3] == $past(core.liveResult[4:0], 4))
  ) else $error("lower result bits not in bits 7 to 3");

  a_reserved_zero: assert property (
    lowerRead |=> (avsReaddata[2:1] == 2'h0) && (avsReaddata[31:8] == 24'h00_0000)
  ) else $error("reserved lower bits not zero");

  a_overflow_snap: assert property (
    upperRead |=> (lowerLatch_q[0] == $past(core.liveOverflow))
  ) else $error("overflow flag not captured");

  a_lower_latch_capture: assert property (
    upperRead |=> (lowerLatch_q == {$past(core.liveResult[4:0]), 2'h0, $past(core.liveOverflow)})
  ) else $error("upper read did not capture low bits");

  a_lower_read_match: assert property (
    lowerRead |=> (avsReaddata[7:0] == $past(lowerLatch_q))
  ) else $error("lower read does not return snapshot");

  a_single_invalid: assert property (
    (singleShotActive && !convDone) |=> !resultValid
  ) else $error("result valid during single-shot conversion");

  a_valid_after_done: assert property (
    convDone |=> resultValid [*1] ##0 (core.liveResult == $past(convResult))
  ) else $error("completed conversion not flagged valid");

  a_live_update: assert property (
    convDone ##1 (!convDone && !singleShotActive) [*2] |-> $stable(core.liveResult)
  ) else $error("result changed without a conversion");

  a_live_tracks: assert property (
    (convDone && !upperRead) ##1 (!convDone [*2]) ##1 upperRead |=>
      (avsReaddata[7:0] == $past(convResult[12:5], 4))
  ) else $error("upper read missed most recent conversion");

  a_write_no_effect: assert property (
    (core.writeStrobe && !convDone) |=> $stable(core.liveResult) && $stable(core.liveOverflow)
      && $stable(lowerLatch_q)
  ) else $error("write altered stored result");

  a_write_answer: assert property (
    core.writeStrobe |=> !avsWaitrequest ##1 avsWaitrequest
  ) else $error("write not answered in one cycle");

  a_reset_no_valid: assert property (
    $rose(rst_b) |-> !resultValid
  ) else $error("result claimed valid straight after reset");

  a_latch_hold: assert property (
    !upperRead |=> $stable(lowerLatch_q)
  ) else $error("snapshot changed without an upper read");

  a_latch_hold_conv: assert property (
    (upperRead ##1 (!upperRead && convDone)) |=> $stable(lowerLatch_q)
  ) else $error("new conversion disturbed the snapshot");

  a_bus_answer: assert property (
    ((avsRead || avsWrite) && avsWaitrequest) |=> !avsWaitrequest
  ) else $error("request not answered in one cycle");

  a_single_strobe: assert property (
    core.readStrobe |=> !core.readStrobe
  ) else $error("read strobed twice for one transfer");

  a_unmapped_zero: assert property (
    (core.readStrobe && !core.selUpper && !core.selLower) |=> (avsReaddata == 32'h0000_0000)
  ) else $error("unmapped read not zero");

  a_wait_idle_high: assert property (
    !(avsRead || avsWrite) |=>
      avsWaitrequest
  ) else $error("waitrequest low without a request");

  a_wait_pulse_one: assert property (
    !avsWaitrequest |=>
      avsWaitrequest
  ) else $error("waitrequest low for more than one cycle");

  a_wait_fall_cause: assert property (
    $fell(avsWaitrequest) |->
      $past(avsRead || avsWrite)
  ) else $error("answer given with no request taken");

  a_strobe_in_idle: assert property (
    (core.readStrobe || core.writeStrobe) |->
      avsWaitrequest
  ) else $error("strobe outside the idle state");

  a_answer_no_strobe: assert property (
    !avsWaitrequest |->
      (!core.readStrobe && !core.writeStrobe)
  ) else $error("strobe during the answer cycle");

  a_rdata_steady: assert property (
    !core.readStrobe |=>
      $stable(avsReaddata)
  ) else $error("read data changed without a read");

  a_rdata_pad_zero: assert property (
    avsReaddata[31:8] == 24'h00_0000
  ) else $error("read data upper bits not zero");

  a_sel_onehot: assert property (
    !(core.selUpper && core.selLower)
  ) else $error("both registers selected at once");

  a_answer_follows_read: assert property (
    (avsRead && !avsWaitrequest) |->
      $past(core.readStrobe)
  ) else $error("read answered without a strobe");

  a_write_strobe_once: assert property (
    core.writeStrobe |=>
      !core.writeStrobe
  ) else $error("write strobed twice for one transfer");

  a_write_keeps_rdata: assert property (
    core.writeStrobe |=>
      $stable(avsReaddata)
  ) else $error("write changed read data");

  a_write_keeps_valid: assert property (
    (core.writeStrobe && !convDone && !singleShotActive) |=>
      $stable(resultValid)
  ) else $error("write changed result validity");

  a_write_upper_nosnap: assert property (
    (core.writeStrobe && core.selUpper) |=>
      $stable(lowerLatch_q)
  ) else $error("write to upper register loaded the snapshot");

  a_upper_sign_bit: assert property (
    upperRead |=>
      (avsReaddata[7] == $past(core.liveResult[12]))
  ) else $error("sign bit not in upper bit 7");

  a_overflow_tracks: assert property (
    convDone |=>
      (core.liveOverflow == $past(convOverflow))
  ) else $error("overflow not taken from conversion");

  a_latch_rsvd_zero: assert property (
    lowerLatch_q[2:1] == 2'h0
  ) else $error("reserved snapshot bits not zero");

  a_lower_flag_pos: assert property (
    lowerRead |=>
      (avsReaddata[0] == $past(lowerLatch_q[0]))
  ) else $error("overflow flag not in bit 0");

  a_other_read_nosnap: assert property (
    (core.readStrobe && !core.selUpper) |=>
      $stable(lowerLatch_q)
  ) else $error("snapshot loaded by a read other than upper");

  a_valid_steady: assert property (
    (!convDone && !singleShotActive) |=>
      $stable(resultValid)
  ) else $error("validity changed without cause");

  a_done_beats_single: assert property (
    (convDone && singleShotActive) |=>
      resultValid
  ) else $error("completion lost to single-shot in same cycle");

  a_invalid_stays: assert property (
    (!resultValid && !convDone) |=>
      !resultValid
  ) else $error("result became valid without a conversion");

  a_single_keeps_result: assert property (
    (singleShotActive && !convDone) |=>
      $stable(core.liveResult)
  ) else $error("result changed while single-shot runs");

  a_result_steady: assert property (
    !convDone |=>
      $stable(core.liveResult) && $stable(core.liveOverflow)
  ) else $error("stored result changed without completion");

  a_lower_read_keep: assert property (
    lowerRead |=>
      $stable(lowerLatch_q)
  ) else $error("lower read disturbed the snapshot");

  a_latch_next_upper: assert property (
    upperRead ##1 (!upperRead [*3]) |->
      $stable(lowerLatch_q)
  ) else $error("snapshot moved before the next upper read");
endmodule

// *** shared/arr_core_if.sv ***
// Internal carrier between the bus slave, the result capture and the register core
`timescale 1ns/10ps
interface arr_core_if;
  logic                          readStrobe;
  logic                          writeStrobe;
  logic                          selUpper;
  logic                          selLower;
  logic [7:0]                    readByte;
  logic [12:0]                   liveResult;
  logic                          liveOverflow;

  modport slave (
    output readStrobe,
    output writeStrobe,
    output selUpper,
    output selLower,
    input  readByte
  );
  modport capture (
    output liveResult,
    output liveOverflow
  );
  modport core (
    input  readStrobe,
    input  writeStrobe,
    input  selUpper,
    input  selLower,
    input  liveResult,
    input  liveOverflow,
    output readByte
  );
endinterface

// *** shared/arr_pkg.sv ***
// Constants and types shared by the converter result register block
package arr_pkg;
  // Result and byte geometry
  localparam int unsigned     RESULT_W    = 13;
  localparam int unsigned     BYTE_W      = 8;
  localparam int unsigned     UPPER_MSB   = 12;
  localparam int unsigned     UPPER_LSB   = 5;
  localparam int unsigned     LOW_MSB     = 4;
  localparam int unsigned     LOW_FLD_MSB = 7;
  localparam int unsigned     LOW_FLD_LSB = 3;
  localparam int unsigned     OVF_BIT     = 0;
  localparam logic [1:0]      RSVD_VALUE  = 2'h0;
  // Avalon-MM geometry
  localparam int unsigned     ADDR_W      = 14;
  localparam int unsigned     DATA_W      = 32;
  localparam int unsigned     BE_W        = 4;
  localparam int unsigned     IDX_LSB     = 2;
  localparam int unsigned     IDX_W       = 12;
  // Register indices; byte address is four times the index
  localparam logic [11:0]     UPPER_IDX   = 12'hF72;
  localparam logic [11:0]     LOWER_IDX   = 12'hF73;
  // Reset values
  localparam logic [12:0]     RESULT_RST  = 13'h0000;
  localparam logic [7:0]      BYTE_RST    = 8'h00;
  localparam logic [31:0]     RDATA_RST   = 32'h0000_0000;
  localparam logic [23:0]     RDATA_PAD   = 24'h00_0000;

  typedef enum logic {
    ST_IDLE,
    ST_ANSWER
  } arr_bus_state_type;

  // True when a byte address selects the given register index
  function automatic logic arr_hit(input logic [13:0] addr, input logic [11:0] idx);
    arr_hit = (addr[13:2] == idx);
  endfunction
endpackage

// *** verification/arr_result_registers_bench.sv ***
// Self-checking bench for the converter result registers, with an integer reference model
`timescale 1ns/10ps
module arr_result_registers_bench;
  localparam logic [13:0] UPPER_ADDR = {arr_pkg::UPPER_IDX, 2'h0};
  localparam logic [13:0] LOWER_ADDR = {arr_pkg::LOWER_IDX, 2'h0};
  localparam logic [13:0] SPARE_ADDR = 14'h0010;
  localparam int          CYCLE_CAP  = 20000;

  // Clock and reset
  logic        ref_clk;
  logic        rst_b;
  // Avalon-MM
  logic [13:0] avsAddress;
  logic        avsRead;
  logic        avsWrite;
  logic [31:0] avsWritedata;
  logic [3:0]  avsByteenable;
  logic [31:0] avsReaddata;
  logic        avsWaitrequest;
  // Converter
  logic        convDone;
  logic [12:0] convResult;
  logic        convOverflow;
  logic        singleShotActive;
  logic        resultValid;

  int          miscompares;
  int          n_checks;
  int          seed;
  int          cycles;
  // Reference model: latest result, overflow and the lower-byte snapshot
  int          mRes;
  int          mOvf;
  int          mSnap;
  int          convLog[$];
  logic [31:0] rd;

  arr_result_registers arr_result_registers_i (
    .ref_clk         (ref_clk),
    .rst_b           (rst_b),
    .avsAddress      (avsAddress),
    .avsRead         (avsRead),
    .avsWrite        (avsWrite),
    .avsWritedata    (avsWritedata),
    .avsByteenable   (avsByteenable),
    .avsReaddata     (avsReaddata),
    .avsWaitrequest  (avsWaitrequest),
    .convDone        (convDone),
    .convResult      (convResult),
    .convOverflow    (convOverflow),
    .singleShotActive(singleShotActive),
    .resultValid     (resultValid)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic final_report();
    if (miscompares == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // A hang anywhere ends the run through the same report
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == CYCLE_CAP) begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: run did not finish", $time);
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One Avalon transfer; values sampled at an edge are those before that edge's updates
  task automatic bus(input logic wr, input logic [13:0] addr, output logic [31:0] data);
    @(posedge ref_clk);
    avsRead       <= ~wr;
    avsWrite      <= wr;
    avsAddress    <= addr;
    avsWritedata  <= $random(seed);
    avsByteenable <= 4'($random(seed));
    // Only the bench timeout ends a wait that never gets an answer
    do begin
      @(posedge ref_clk);
    end while (avsWaitrequest !== 1'b0);
    data = avsReaddata;
    avsRead  <= 1'b0;
    avsWrite <= 1'b0;
  endtask

  task automatic conv(input int res, input int ovf);
    @(posedge ref_clk);
    convDone     <= 1'b1;
    convResult   <= 13'(res);
    convOverflow <= 1'(ovf);
    @(posedge ref_clk);
    convDone <= 1'b0;
    convLog.push_back(res & 32'h1FFF);
    mRes = convLog[$];
    mOvf = ovf & 1;
  endtask

  function automatic logic [31:0] upperExp();
    return 32'((mRes >> 5) & 32'hFF);
  endfunction

  function automatic logic [31:0] snapExp();
    return 32'(((mRes & 32'h1F) << 3) | mOvf);
  endfunction

  initial begin
    seed = 51;
    miscompares = 0;
    n_checks = 0;
    mSnap = 0;
    rst_b = 1'b0;
    avsAddress = 14'h0000;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWritedata = 32'h0000_0000;
    avsByteenable = 4'h0;
    convDone = 1'b0;
    convResult = 13'h0000;
    convOverflow = 1'b0;
    singleShotActive = 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      // Corner values first, so both signs and the extremes of the field are seen
      conv((i == 0) ? 32'h0FFF : (i == 1) ? 32'h1000 : (i == 2) ? 32'h1FFF : $random(seed), $random(seed));
      @(posedge ref_clk);
      check({31'h0, resultValid}, 32'h1, "valid after conversion");
      bus(1'b0, UPPER_ADDR, rd);
      mSnap = snapExp();
      check(rd, upperExp(), "upper byte");
      // A newer conversion must not disturb the snapshot taken by the upper read
      conv($random(seed), $random(seed));
      bus(1'b1, UPPER_ADDR, rd);
      bus(1'b1, LOWER_ADDR, rd);
      bus(1'b0, LOWER_ADDR, rd);
      check(rd, 32'(mSnap), "lower byte snapshot");
      bus(1'b0, LOWER_ADDR, rd);
      check(rd, 32'(mSnap), "lower byte reread");
      bus(1'b0, UPPER_ADDR, rd);
      mSnap = snapExp();
      check(rd, upperExp(), "upper after writes");
      bus(1'b0, LOWER_ADDR, rd);
      check(rd, 32'(mSnap), "lower after upper");
    end
    bus(1'b0, SPARE_ADDR, rd);
    check(rd, 32'h0, "unmapped read");
    // Single-shot run marks the result invalid until the next completion
    @(posedge ref_clk);
    singleShotActive <= 1'b1;
    @(posedge ref_clk);
    @(posedge ref_clk);
    check({31'h0, resultValid}, 32'h0, "invalid during single shot");
    conv($random(seed), 1);
    singleShotActive <= 1'b0;
    @(posedge ref_clk);
    check({31'h0, resultValid}, 32'h1, "valid at completion");
    bus(1'b0, UPPER_ADDR, rd);
    check(rd, upperExp(), "upper after single shot");
    bus(1'b0, LOWER_ADDR, rd);
    check(rd, snapExp(), "overflow flag set");
    final_report();
  end
endmodule
